// *** hdl/prdc_delay.sv ***
// Delays each transition of the scheduled PWM that arrives while no delay is pending by a count of instruction cycles.
// Assumes instr_tick pulses once every instruction cycle.
module prdc_delay
	import prdc_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic nrst,
	prdc_dly_if.unit  dly
);
	logic               out_q,  out_d;
	logic               busy_q, busy_d;
	logic [DELAY_W-1:0] cnt_q,  cnt_d;

	always_comb begin
		out_d  = out_q;
		busy_d = busy_q;
		cnt_d  = cnt_q;
		if (dly.pwm_sched != out_q && !busy_q) begin
			if (dly.delay_count == '0) begin
				out_d = dly.pwm_sched;
			end else begin
				busy_d = 1'b1;
				cnt_d  = dly.delay_count;
			end
		end else if (busy_q && dly.instr_tick) begin
			// A transition pulled back while waiting is simply not emitted
			if (cnt_q == 7'h01) begin
				busy_d = 1'b0;
				out_d  = dly.pwm_sched;
			end
			cnt_d = cnt_q - 7'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			out_q  <= 1'b0;
			busy_q <= 1'b0;
			cnt_q  <= '0;
		end else begin
			out_q  <= out_d;
			busy_q <= busy_d;
			cnt_q  <= cnt_d;
		end
	end

	assign dly.pwm_delayed = out_q;
endmodule // prdc_delay

// *** hdl/prdc_dly_if.sv ***
// Carrier between the control top and its transition delay unit.
// Assumes both ends run on core_clk.
interface prdc_dly_if;
	logic                       pwm_sched;
	logic [prdc_pkg::DELAY_W-1:0] delay_count;
	logic                       instr_tick;
	logic                       pwm_delayed;
	modport ctrl (output pwm_sched, output delay_count, output instr_tick, input pwm_delayed);
	modport unit (input pwm_sched, input delay_count, input instr_tick, output pwm_delayed);
endinterface

// *** hdl/prdc_pkg.sv ***
// Constants for the PWM restart and transition delay control block.
// Assumes a 32-bit AXI4-Lite register bus and one core clock.
package prdc_pkg;
	localparam int          CORE_CLK_HZ     = 50_000_000;
	localparam int          CLKS_PER_INSTR  = 4;
	localparam logic [1:0]  INSTR_LAST      = 2'(CLKS_PER_INSTR - 1);
	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  OFS_CTRL        = 8'h00;
	localparam logic [7:0]  OFS_STATUS      = 8'h04;
	localparam logic [7:0]  OFS_CONFIG      = 8'h08;
	localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h0C;
	localparam logic [7:0]  OFS_IRQ_CLEAR   = 8'h10;
	localparam logic [7:0]  OFS_IRQ_ENABLE  = 8'h14;
	localparam int          CTRL_RESTART    = 7;
	localparam int          DELAY_W         = 7;
	localparam logic [7:0]  CTRL_RESET      = 8'h00;
	localparam int          IRQ_N           = 2;
	localparam int          IRQ_SHUTDOWN    = 0;
	localparam int          IRQ_RESTART     = 1;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// *** hdl/prdc_top.sv ***
// PWM auto-restart and transition delay control with an AXI4-Lite register slave.
// Assumes fault, comparator and Timer1 inputs are asynchronous; pwm_sched is on core_clk.
module prdc_top
	import prdc_pkg::*;
(
	input  wire logic                       core_clk,
	input  wire logic                       nrst,
	input  wire logic [prdc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [prdc_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       fault_pin,
	input  wire logic                       comparator_trip,
	input  wire logic                       timer1_clk,
	input  wire logic                       pwm_sched,
	output logic                            pwm_out,
	output logic                            shutdown_event_status,
	output logic                            irq
);
	prdc_dly_if dly ();

	// Two-stage synchronisers for the three asynchronous inputs
	logic [2:0] sync1_q, sync2_q, sync_in;
	logic       t1_prev_q;
	assign sync_in = {timer1_clk, comparator_trip, fault_pin};
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			sync1_q   <= '0;
			sync2_q   <= '0;
			t1_prev_q <= 1'b0;
		end else begin
			sync1_q   <= sync_in;
			sync2_q   <= sync1_q;
			t1_prev_q <= sync2_q[2];
		end
	end
	logic fault_s, comp_s, t1_rise;
	assign fault_s = sync2_q[0];
	assign comp_s  = sync2_q[1];
	assign t1_rise = sync2_q[2] & ~t1_prev_q;

	// Instruction cycle phase: one instruction cycle is four core clocks
	logic [1:0] phase_q, phase_d;
	always_comb phase_d = (phase_q == INSTR_LAST) ? 2'h0 : phase_q + 2'h1;

	// Registers
	logic [7:0]       ctrl_q,  ctrl_d;
	logic             csync_q, csync_d;
	logic             comp_eff_q, comp_eff_d;
	logic             sd_q,    sd_d;
	logic [IRQ_N-1:0] ists_q,  ists_d;
	logic [IRQ_N-1:0] ien_q,   ien_d;
	logic             pwm_q,   pwm_d;
	logic             irq_q,   irq_d;

	// AXI4-Lite write and read channel state
	logic             aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [31:0]      wdata_q, wdata_d;
	logic [3:0]       wstrb_q, wstrb_d;
	logic             bvalid_q, bvalid_d;
	logic [1:0]       bresp_q, bresp_d;
	logic             rvalid_q, rvalid_d;
	logic [1:0]       rresp_q, rresp_d;
	logic [31:0]      rdata_q, rdata_d;
	// Ready outputs are registered inverses of the next holding state
	logic             awready_q, awready_d, wready_q, wready_d;
	logic             arready_q, arready_d;

	logic wr_fire, rd_fire, event_active, sw_clear;
	assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
	assign rd_fire = s_axi_arvalid & ~rvalid_q;

	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d  = w_have_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		ctrl_d    = ctrl_q;
		csync_d   = csync_q;
		ien_d     = ien_q;
		sw_clear  = 1'b0;
		ists_d    = ists_q;

		if (s_axi_awvalid && !aw_have_q) begin
			aw_have_d = 1'b1;
			awaddr_d  = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_have_q) begin
			w_have_d = 1'b1;
			wdata_d  = s_axi_wdata;
			wstrb_d  = s_axi_wstrb;
		end
		if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
		if (wr_fire) begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = RESP_OKAY;
			unique case ({awaddr_q[ADDR_W-1:2], 2'b00})
				OFS_CTRL:       if (wstrb_q[0]) ctrl_d = wdata_q[7:0];
				OFS_STATUS:     if (wstrb_q[0] && !wdata_q[0]) sw_clear = 1'b1;
				OFS_CONFIG:     if (wstrb_q[0]) csync_d = wdata_q[0];
				OFS_IRQ_CLEAR:  if (wstrb_q[0]) ists_d = ists_q & ~wdata_q[IRQ_N-1:0];
				OFS_IRQ_ENABLE: if (wstrb_q[0]) ien_d = wdata_q[IRQ_N-1:0];
				OFS_IRQ_STATUS: ;
				default:        bresp_d = RESP_SLVERR;
			endcase
		end

		if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
		if (rd_fire) begin
			rvalid_d = 1'b1;
			rresp_d  = RESP_OKAY;
			rdata_d  = 32'h0000_0000;
			unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
				OFS_CTRL:       rdata_d[7:0] = ctrl_q;
				OFS_STATUS:     rdata_d[0] = sd_q;
				OFS_CONFIG:     rdata_d[0] = csync_q;
				OFS_IRQ_STATUS: rdata_d[IRQ_N-1:0] = ists_q;
				OFS_IRQ_ENABLE: rdata_d[IRQ_N-1:0] = ien_q;
				OFS_IRQ_CLEAR:  ;
				default:        rresp_d = RESP_SLVERR;
			endcase
		end

		// Comparator trip either acts at once or on the next Timer1 rising edge
		if (!csync_q) comp_eff_d = comp_s;
		else if (t1_rise) comp_eff_d = comp_s;
		else comp_eff_d = comp_eff_q;
		event_active = fault_s | comp_eff_q;

		// Event wins over any clear in the same cycle
		if (event_active) sd_d = 1'b1;
		else if (sd_q && ctrl_q[CTRL_RESTART]) sd_d = 1'b0;
		else if (sw_clear) sd_d = 1'b0;
		else sd_d = sd_q;

		if (event_active && !sd_q) ists_d[IRQ_SHUTDOWN] = 1'b1;
		if (sd_q && !sd_d) ists_d[IRQ_RESTART] = 1'b1;

		// Shutdown drives the output low regardless of pending transitions
		pwm_d = sd_q ? 1'b0 : dly.pwm_delayed;
		irq_d = |(ists_q & ien_q);

		awready_d = ~aw_have_d;
		wready_d  = ~w_have_d;
		arready_d = ~rvalid_d;
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			phase_q    <= 2'h0;
			ctrl_q     <= CTRL_RESET;
			csync_q    <= 1'b0;
			comp_eff_q <= 1'b0;
			sd_q       <= 1'b0;
			ists_q     <= '0;
			ien_q      <= '0;
			pwm_q      <= 1'b0;
			irq_q      <= 1'b0;
			aw_have_q  <= 1'b0;
			w_have_q   <= 1'b0;
			awaddr_q   <= '0;
			wdata_q    <= '0;
			wstrb_q    <= '0;
			bvalid_q   <= 1'b0;
			bresp_q    <= RESP_OKAY;
			rvalid_q   <= 1'b0;
			rresp_q    <= RESP_OKAY;
			rdata_q    <= '0;
			awready_q  <= 1'b1;
			wready_q   <= 1'b1;
			arready_q  <= 1'b1;
		end else begin
			phase_q    <= phase_d;
			ctrl_q     <= ctrl_d;
			csync_q    <= csync_d;
			comp_eff_q <= comp_eff_d;
			sd_q       <= sd_d;
			ists_q     <= ists_d;
			ien_q      <= ien_d;
			pwm_q      <= pwm_d;
			irq_q      <= irq_d;
			aw_have_q  <= aw_have_d;
			w_have_q   <= w_have_d;
			awaddr_q   <= awaddr_d;
			wdata_q    <= wdata_d;
			wstrb_q    <= wstrb_d;
			bvalid_q   <= bvalid_d;
			bresp_q    <= bresp_d;
			rvalid_q   <= rvalid_d;
			rresp_q    <= rresp_d;
			rdata_q    <= rdata_d;
			awready_q  <= awready_d;
			wready_q   <= wready_d;
			arready_q  <= arready_d;
		end
	end

	assign dly.pwm_sched   = pwm_sched;
	assign dly.delay_count = ctrl_q[DELAY_W-1:0];
	assign dly.instr_tick  = (phase_q == INSTR_LAST);

	prdc_delay u_delay (
		.core_clk (core_clk),
		.nrst     (nrst),
		.dly      (dly)
	);

	assign s_axi_awready         = awready_q;
	assign s_axi_wready          = wready_q;
	assign s_axi_bvalid          = bvalid_q;
	assign s_axi_bresp           = bresp_q;
	assign s_axi_arready         = arready_q;
	assign s_axi_rvalid          = rvalid_q;
	assign s_axi_rresp           = rresp_q;
	assign s_axi_rdata           = rdata_q;
	assign pwm_out               = pwm_q;
	assign shutdown_event_status = sd_q;
	assign irq                   = irq_q;
endmodule // prdc_top

// *** testbench/prdc_top_asserts.sv ***
// Port-level checker for prdc_top, bound into every instance.
// Assumes one clock, core_clk, and a synchronous active-low nrst.
module prdc_top_chk (
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        fault_pin,
	input wire logic        pwm_sched,
	input wire logic        pwm_out,
	input wire logic        shutdown_event_status,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	property p_rst;
		$rose(nrst) |-> s_axi_awready && !s_axi_bvalid && !shutdown_event_status && !pwm_out;
	endproperty
	a_rst: assert property (p_rst) else $error("state not clear after reset");
	property p_mask; shutdown_event_status |=> !pwm_out; endproperty
	a_mask: assert property (p_mask) else $error("pwm not held off in shutdown");
	property p_flt; fault_pin [*5] |-> shutdown_event_status; endproperty
	a_flt: assert property (p_flt) else $error("fault did not set flag");
	property p_fall; $fell(shutdown_event_status) |-> !$past(fault_pin, 3); endproperty
	a_fall: assert property (p_fall) else $error("flag released during fault");
	// Right after a flag change the mask, not the delay path, sets pwm_out
	property p_dly;
		$changed(pwm_out) && !$past(shutdown_event_status) && !$past(shutdown_event_status, 2)
			|-> pwm_out == $past(pwm_sched, 2);
	endproperty
	a_dly: assert property (p_dly) else $error("pwm took a stale value");
	property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_wr: assert property (p_wr) else $error("write response late");
	property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd: assert property (p_rd) else $error("read response late");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read data not held");
	c_sd: cover property ($rose(shutdown_event_status));
	c_rel: cover property ($fell(shutdown_event_status));
	c_irq: cover property ($rose(irq));
endmodule // prdc_top_chk

bind prdc_top prdc_top_chk u_chk (.*);

// *** testbench/prdc_top_tb.sv ***
// Self-checking bench for prdc_top: register bus, delay and shutdown.
// Assumes the package, design and checker are compiled before it.
module prdc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import prdc_pkg::*;
	logic              core_clk = 0, nrst = 0;
	logic [ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0]       s_axi_wdata = 0, s_axi_rdata, v;
	logic [3:0]        s_axi_wstrb = 4'hF;
	logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic              s_axi_arvalid = 0, s_axi_rready = 0;
	logic              fault_pin = 0, comparator_trip = 0, timer1_clk = 0, pwm_sched = 0;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic              pwm_out, shutdown_event_status, irq;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	int                n_fail = 0, tests_run = 0, seed = 32'he612, n;
	prdc_top dut (.*);
	always #10 core_clk = ~core_clk;
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %0h got %0h", nm, e, g);
		end
	endtask
	// Handshakes are sampled at the falling edge so the rising edge sees settled values
	task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er = RESP_OKAY);
		logic aw, w, b;
		logic [1:0] r;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (int i = 0; i < 99; i++) begin
			@(negedge core_clk);
			{aw, w, b, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
			@(posedge core_clk);
			if (aw) s_axi_awvalid <= 1'h0;
			if (w) s_axi_wvalid <= 1'h0;
			if (b) break;
		end
		s_axi_bready <= 1'h0;
		// Let an edge pass so a following write never reassigns in this step
		@(posedge core_clk);
		chk("bresp", 32'(er), 32'(r));
	endtask
	// Ready is raised late on purpose so the data must stand while unaccepted
	task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er = RESP_OKAY);
		logic ar, rv;
		logic [31:0] d;
		logic [1:0] r;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		for (int i = 0; i < 99; i++) begin
			@(negedge core_clk);
			{ar, rv, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge core_clk);
			if (ar) s_axi_arvalid <= 1'h0;
			if (rv && s_axi_rready) break;
			s_axi_rready <= rv;
		end
		s_axi_rready <= 1'h0;
		chk("rdata", ed, d);
		chk("rresp", 32'(er), 32'(r));
	endtask
	task automatic st(logic [2:0] e);
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		chk("flag", 32'(e[2]), 32'(shutdown_event_status));
		chk("irq", 32'(e[1]), 32'(irq));
		chk("pwm", 32'(e[0]), 32'(pwm_out));
		@(posedge core_clk);
	endtask
	// Tick phase is free running, so a nonzero count lands within a window
	function automatic logic dly_ok(int d, int m);
		return d == 0 ? m == 2 : (m >= 4 * d - 1 && m <= 4 * d + 5);
	endfunction
	task automatic dl(int d);
		wr(OFS_CTRL, 32'(d));
		pwm_sched <= ~pwm_sched;
		for (n = 0; n < 600; n++) begin
			@(negedge core_clk);
			if (pwm_out === pwm_sched) break;
			@(posedge core_clk);
		end
		@(posedge core_clk);
		chk("delay", 32'h1, 32'(dly_ok(d, n)));
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		tally_and_finish;
	end
	initial begin
		repeat (20) @(posedge core_clk);
		nrst <= 1'h1;
		@(posedge core_clk);
		rd(OFS_CTRL, 32'h0);
		rd(OFS_STATUS, 32'h0);
		repeat (3) begin
			v = $random(seed);
			wr(OFS_CTRL, v);
			rd(OFS_CTRL, {24'h0, v[7:0]});
		end
		s_axi_wstrb <= 4'h0;
		wr(OFS_CTRL, ~v);
		s_axi_wstrb <= 4'hF;
		rd(OFS_CTRL, {24'h0, v[7:0]});
		wr(8'h40, v, RESP_SLVERR);
		rd(8'h40, 32'h0, RESP_SLVERR);
		dl(0);
		dl(127);
		dl(1);
		repeat (2) dl($random(seed) & 32'h7F);
		wr(OFS_IRQ_ENABLE, 32'h3);
		fault_pin <= 1'h1;
		st(3'h6);
		fault_pin <= 1'h0;
		st(3'h6);
		rd(OFS_IRQ_STATUS, 32'h1);
		wr(OFS_STATUS, 32'h0);
		st(3'h3);
		rd(OFS_IRQ_STATUS, 32'h3);
		wr(OFS_IRQ_CLEAR, 32'h3);
		st(3'h1);
		wr(OFS_IRQ_ENABLE, 32'h0);
		wr(OFS_CTRL, 32'h80);
		fault_pin <= 1'h1;
		st(3'h4);
		fault_pin <= 1'h0;
		st(3'h1);
		wr(OFS_CONFIG, 32'h1);
		rd(OFS_CONFIG, 32'h1);
		comparator_trip <= 1'h1;
		st(3'h1);
		timer1_clk <= 1'h1;
		st(3'h4);
		{comparator_trip, timer1_clk} <= 2'h0;
		st(3'h4);
		timer1_clk <= 1'h1;
		st(3'h1);
		wr(OFS_CONFIG, 32'h0);
		comparator_trip <= 1'h1;
		st(3'h4);
		comparator_trip <= 1'h0;
		st(3'h1);
		tally_and_finish;
	end
endmodule // prdc_top_tb
